/* include/flash_host_cfg.svh */
// flash_host_cfg.svh: constants for the parallel NOR flash host controller
// assumes a 40 MHz sys_clk and a 16-bit word-wide flash with a 26-bit word address
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define FH_ADDR_W          26
`define FH_DATA_W          16
`define FH_SECTOR_LSB      16

// ----------------------------------------
// command codes and unlock addresses
// ----------------------------------------
`define FH_UNLOCK1_ADDR    26'h0000555
`define FH_UNLOCK2_ADDR    26'h00002aa
`define FH_D_UNLOCK1       16'h00aa
`define FH_D_UNLOCK2       16'h0055
`define FH_D_RESET         16'h00f0
`define FH_D_BYPASS_ENTRY  16'h0020
`define FH_D_AUTOSELECT    16'h0090
`define FH_D_EXIT1         16'h0090
`define FH_D_EXIT2         16'h0000
`define FH_D_LOCK_ENTRY    16'h0040
`define FH_D_GUARD_ENTRY   16'h00c0
`define FH_D_PROGRAM       16'h00a0
`define FH_D_GUARD_SET     16'h0000
`define FH_D_ERASE1        16'h0080
`define FH_D_ERASE2        16'h0030

// ----------------------------------------
// bit positions
// ----------------------------------------
`define FH_LOCK_PWD_BIT    2
`define FH_LOCK_PERS_BIT   1
`define FH_LOCK_SECURE_BIT 0
`define FH_TIMEOUT_BIT     5
`define FH_ABORT_BIT       1

// ----------------------------------------
// timing
// ----------------------------------------
`define FH_CLK_NS          25
`define FH_RESTART_NS      500
`define FH_WE_NS           50
`define FH_READ_NS         100
`define FH_SYNC_LAT        2
`define FH_RP_CYC          ((`FH_RESTART_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_WE_CYC          ((`FH_WE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_READ_CYC        (((`FH_READ_NS + `FH_CLK_NS - 1) / `FH_CLK_NS) + `FH_SYNC_LAT)
`define FH_SETTLE_CYC      (`FH_SYNC_LAT + 1)

`endif

/* include/flash_host_pkg.sv */
// flash_host_pkg: types shared by the flash host controller files
// assumes flash_host_cfg.svh is on the include path
`include "flash_host_cfg.svh"

package flash_host_pkg;

  typedef enum logic [3:0] {
    CMD_READ            = 4'h0,
    CMD_STATUS          = 4'h1,
    CMD_RESTART         = 4'h2,
    CMD_WRITE_RAW       = 4'h3,
    CMD_SW_RESET        = 4'h4,
    CMD_BUF_ABORT_RESET = 4'h5,
    CMD_BYPASS_ENTRY    = 4'h6,
    CMD_BYPASS_RESET    = 4'h7,
    CMD_AUTOSELECT      = 4'h8,
    CMD_LOCK_ENTRY      = 4'h9,
    CMD_LOCK_PROGRAM    = 4'ha,
    CMD_GUARD_ENTRY     = 4'hb,
    CMD_GUARD_PROGRAM   = 4'hc,
    CMD_GUARD_ERASE     = 4'hd,
    CMD_EXIT            = 4'he
  } cmd_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_SETUP   = 3'h1,
    ST_STROBE  = 3'h3,
    ST_HOLD    = 3'h2,
    ST_SETTLE  = 3'h6,
    ST_POLL    = 3'h7,
    ST_READ    = 3'h5,
    ST_RESTART = 3'h4
  } fsm_state_type;

  typedef struct packed {
    logic                  ceN;
    logic                  weN;
    logic                  oeN;
    logic                  restartN;
    logic                  dqEnN;
    logic [`FH_ADDR_W-1:0] addr;
    logic [`FH_DATA_W-1:0] dq;
  } flash_pins_type;

  typedef struct packed {
    logic [`FH_ADDR_W-1:0] addr;
    logic [`FH_DATA_W-1:0] data;
    logic                  last;
  } seq_step_type;

endpackage : flash_host_pkg

/* hdl/sync_two_stage.sv */
// sync_two_stage: two-flop synchroniser for a bundle of pin inputs
// assumes each bit is an independent level; no word coherence is promised
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta[b]   <= 1'b1;
          synced[b] <= 1'b1;
        end else begin
          meta[b]   <= async[b];
          synced[b] <= meta[b];
        end
      end
    end
  endgenerate

endmodule : sync_two_stage

`default_nettype wire

/* hdl/flash_host_ctrl.sv */
// flash_host_ctrl: host-side command sequencer for a parallel NOR flash
// assumes the flash pins are outside sys_clk and the user side is on sys_clk
//
// Summary of operation
// [R1] write cycle: chip select, strobe low, output-enable high
// [R2] address stable at fall, data across rise; the code drives the address on the same edge as the strobe fall
// [R3] sector address is the upper address bits
// [R4] ready/busy polled only after final strobe rise
// [R5] restart pin held low the minimum pulse
// [R6] software reset writes F0, any address
// [R7] device ignores reset while program/erase runs
// [R8] reset before third program cycle cancels it
// [R9] suspended sector returns to erase-suspend-read
// [R10] host resets after autoselect, timeout, lock, abort
// [R11] buffer abort needs its own reset sequence
// [R12] unlock bypass left by two-cycle reset
// [R13] factory state: persistent mode, all unprotected
// [R14] lock bits: password 2, persistent 1, secure 0
// [R15] clearing both mode locks together aborts
// [R16] one mode lock disables the other forever
// [R17] lock entry blocks sector 0 until exit
// [R18] guard bits programmed singly, erased together
// [R19] guard programming blocks sector 0 and target
// [R20] guard mode reads return guard state
// [R21] frozen guard bits: program/erase times out
// [R22] host issues exit after guard operations
// [R23] guard freeze cleared only by restart
// [R24] resets clear partial unlock-cycle state
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  cmdValid,
  input  wire cmd_kind_type          cmdKind,
  input  wire logic [`FH_ADDR_W-1:0] cmdAddr,
  input  wire logic [`FH_DATA_W-1:0] cmdData,
  output logic                       cmdReady,
  output logic                       done,
  output logic                       error,
  output logic      [`FH_DATA_W-1:0] rdData,
  output logic                       timeoutSeen,
  output logic                       abortSeen,
  output logic                       flashCeN,
  output logic                       flashWeN,
  output logic                       flashOeN,
  output logic                       flashRestartN,
  output logic      [`FH_ADDR_W-1:0] flashAddr,
  output logic      [`FH_DATA_W-1:0] flashDqOut,
  output logic                       flashDqEnN,
  input  wire logic [`FH_DATA_W-1:0] flashDqIn,
  input  wire logic                  readyBusyN
);

  localparam flash_pins_type PINS_IDLE = '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, restartN: 1'b1,
                                            dqEnN: 1'b1, addr: '0, dq: '0};

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  logic [`FH_DATA_W:0] pinSync;
  logic [`FH_DATA_W-1:0] dqSync;
  logic                  rbSync;

  sync_two_stage #(.WIDTH(`FH_DATA_W + 1)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .async   ({readyBusyN, flashDqIn}),
    .synced  (pinSync)
  );

  assign rbSync = pinSync[`FH_DATA_W];
  assign dqSync = pinSync[`FH_DATA_W-1:0];

  // ----------------------------------------
  // command sequences
  // ----------------------------------------
  function automatic seq_step_type seqStep(input cmd_kind_type k, input logic [1:0] i,
                                           input logic [`FH_ADDR_W-1:0] a,
                                           input logic [`FH_DATA_W-1:0] d);
    seq_step_type s;
    logic [`FH_DATA_W-1:0] code;
    s = '{addr: a, data: d, last: 1'b1};
    code = `FH_D_RESET;
    case (k)
      CMD_BYPASS_ENTRY: code = `FH_D_BYPASS_ENTRY;
      CMD_AUTOSELECT:   code = `FH_D_AUTOSELECT;
      CMD_LOCK_ENTRY:   code = `FH_D_LOCK_ENTRY;
      CMD_GUARD_ENTRY:  code = `FH_D_GUARD_ENTRY;
      default:          code = `FH_D_RESET;
    endcase
    case (k)
      CMD_SW_RESET: begin
        s.data = `FH_D_RESET;                                             // R6
      end
      CMD_BUF_ABORT_RESET, CMD_BYPASS_ENTRY, CMD_AUTOSELECT,
      CMD_LOCK_ENTRY, CMD_GUARD_ENTRY: begin
        s.last = (i == 2'h2);
        s.addr = (i == 2'h1) ? `FH_UNLOCK2_ADDR : `FH_UNLOCK1_ADDR;
        s.data = (i == 2'h0) ? `FH_D_UNLOCK1 : ((i == 2'h1) ? `FH_D_UNLOCK2 : code);
      end
      CMD_BYPASS_RESET, CMD_EXIT: begin
        s.last = (i == 2'h1);
        s.data = (i == 2'h0) ? `FH_D_EXIT1 : `FH_D_EXIT2;                  // R12 R22
      end
      CMD_LOCK_PROGRAM: begin
        s.last = (i == 2'h1);
        s.data = (i == 2'h0) ? `FH_D_PROGRAM : {13'h1fff, d[2:0]};         // R14
      end
      CMD_GUARD_PROGRAM: begin
        s.last = (i == 2'h1);
        s.data = (i == 2'h0) ? `FH_D_PROGRAM : `FH_D_GUARD_SET;
        s.addr = {a[`FH_ADDR_W-1:`FH_SECTOR_LSB], 16'h0000};              // R3
      end
      CMD_GUARD_ERASE: begin
        s.last = (i == 2'h1);
        s.data = (i == 2'h0) ? `FH_D_ERASE1 : `FH_D_ERASE2;                // R18
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction : seqStep

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  fsm_state_type         state, next_state;
  cmd_kind_type          kind, next_kind;
  logic [1:0]            step, next_step;
  logic [7:0]            cnt, next_cnt;
  logic [`FH_ADDR_W-1:0] curAddr, next_curAddr;
  logic [`FH_DATA_W-1:0] curData, next_curData;
  flash_pins_type        pins, next_pins;
  logic                  bypassMode, next_bypassMode;
  logic                  cmdSetMode, next_cmdSetMode;
  logic                  next_cmdReady, next_done, next_error;
  logic                  next_timeoutSeen, next_abortSeen;
  logic [`FH_DATA_W-1:0] next_rdData;
  seq_step_type          cur;

  assign cur = seqStep(kind, step, curAddr, curData);

  always_comb begin
    next_state       = state;
    next_kind        = kind;
    next_step        = step;
    next_cnt         = cnt;
    next_curAddr     = curAddr;
    next_curData     = curData;
    next_pins        = pins;
    next_bypassMode  = bypassMode;
    next_cmdSetMode  = cmdSetMode;
    next_timeoutSeen = timeoutSeen;
    next_abortSeen   = abortSeen;
    next_rdData      = rdData;
    next_done        = 1'b0;
    next_error       = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cmdValid && cmdReady) begin
          next_curAddr = cmdAddr;
          next_curData = cmdData;
          next_kind    = cmdKind;
          next_step    = 2'h0;
          if (cmdKind == CMD_READ || cmdKind == CMD_STATUS) begin
            next_pins     = PINS_IDLE;
            next_pins.ceN = 1'b0;
            next_pins.oeN = 1'b0;
            next_pins.addr = cmdAddr;
            next_cnt      = 8'(`FH_READ_CYC);
            next_state    = ST_READ;
          end else if (cmdKind == CMD_RESTART) begin
            next_pins          = PINS_IDLE;
            next_pins.restartN = 1'b0;                                    // R5
            next_cnt           = 8'(`FH_RP_CYC);
            next_state         = ST_RESTART;
          end else if (cmdKind == CMD_LOCK_PROGRAM &&
                       !cmdData[`FH_LOCK_PWD_BIT] && !cmdData[`FH_LOCK_PERS_BIT]) begin
            next_error = 1'b1;                                            // R15
          end else begin
            if (cmdKind == CMD_SW_RESET && abortSeen) begin
              next_kind = CMD_BUF_ABORT_RESET;                            // R11
            end else if (cmdKind == CMD_SW_RESET && bypassMode) begin
              next_kind = CMD_BYPASS_RESET;                               // R12
            end
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // address is driven on the same edge as the strobe fall
        next_pins.ceN   = 1'b0;                                           // R1
        next_pins.oeN   = 1'b1;
        next_pins.dqEnN = 1'b0;
        next_pins.addr  = cur.addr;                                       // R2
        next_pins.dq    = cur.data;
        next_pins.weN   = 1'b0;
        next_cnt        = 8'(`FH_WE_CYC);
        next_state      = ST_STROBE;
      end
      ST_STROBE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_pins.weN = 1'b1;
          next_state    = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // data kept one cycle past the strobe rise
        next_pins.ceN   = 1'b1;
        next_pins.dqEnN = 1'b1;
        if (cur.last) begin
          next_cnt   = 8'(`FH_SETTLE_CYC);                                // R4
          next_state = ST_SETTLE;
          case (kind)
            CMD_SW_RESET: begin
              next_cmdSetMode  = 1'b0;                                    // R10
              next_timeoutSeen = 1'b0;
            end
            CMD_BUF_ABORT_RESET: begin
              next_abortSeen   = 1'b0;                                    // R11
              next_cmdSetMode  = 1'b0;
              next_timeoutSeen = 1'b0;
            end
            CMD_BYPASS_RESET: next_bypassMode = 1'b0;                    // R12
            CMD_BYPASS_ENTRY: next_bypassMode = 1'b1;
            CMD_AUTOSELECT, CMD_LOCK_ENTRY, CMD_GUARD_ENTRY: next_cmdSetMode = 1'b1;
            CMD_EXIT: next_cmdSetMode = 1'b0;                             // R22
            default: next_cmdSetMode = cmdSetMode;
          endcase
        end else begin
          next_step  = step + 2'h1;
          next_state = ST_SETUP;
        end
      end
      ST_SETTLE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_state = ST_POLL;
        end
      end
      ST_POLL: begin
        // busy is only trusted once the synchroniser has seen the final strobe rise
        if (rbSync) begin                                                 // R4
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_READ: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_rdData = dqSync;
          next_pins   = PINS_IDLE;
          next_done   = 1'b1;
          next_state  = ST_IDLE;
          if (kind == CMD_STATUS) begin
            next_timeoutSeen = timeoutSeen | dqSync[`FH_TIMEOUT_BIT];    // R10
            next_abortSeen   = abortSeen | dqSync[`FH_ABORT_BIT];        // R11
          end
        end
      end
      ST_RESTART: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_pins.restartN = 1'b1;
          next_bypassMode    = 1'b0;                                      // R24
          next_cmdSetMode    = 1'b0;
          next_abortSeen     = 1'b0;
          next_timeoutSeen   = 1'b0;
          next_cnt           = 8'(`FH_RP_CYC);
          next_state         = ST_SETTLE;
        end
      end
      default: begin
        next_pins  = PINS_IDLE;
        next_state = ST_IDLE;
      end
    endcase
    next_cmdReady = (next_state == ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      kind        <= CMD_READ;
      step        <= 2'h0;
      cnt         <= 8'h00;
      curAddr     <= '0;
      curData     <= '0;
      pins        <= PINS_IDLE;
      bypassMode  <= 1'b0;
      cmdSetMode  <= 1'b0;
      cmdReady    <= 1'b0;
      done        <= 1'b0;
      error       <= 1'b0;
      rdData      <= '0;
      timeoutSeen <= 1'b0;
      abortSeen   <= 1'b0;
    end else begin
      state       <= next_state;
      kind        <= next_kind;
      step        <= next_step;
      cnt         <= next_cnt;
      curAddr     <= next_curAddr;
      curData     <= next_curData;
      pins        <= next_pins;
      bypassMode  <= next_bypassMode;
      cmdSetMode  <= next_cmdSetMode;
      cmdReady    <= next_cmdReady;
      done        <= next_done;
      error       <= next_error;
      rdData      <= next_rdData;
      timeoutSeen <= next_timeoutSeen;
      abortSeen   <= next_abortSeen;
    end
  end

  assign flashCeN      = pins.ceN;
  assign flashWeN      = pins.weN;
  assign flashOeN      = pins.oeN;
  assign flashRestartN = pins.restartN;
  assign flashAddr     = pins.addr;
  assign flashDqOut    = pins.dq;
  assign flashDqEnN    = pins.dqEnN;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int RP_MIN = `FH_RP_CYC;
  logic [7:0] lowCount;
  always_ff @(posedge sys_clk) begin
    if (rst || flashRestartN) lowCount <= 8'h00;
    else lowCount <= lowCount + 8'h01;
  end

  sequence s_accept(cmd_kind_type k);
    state == ST_IDLE && cmdValid && cmdReady && cmdKind == k;
  endsequence

  property p_write_pins;
    @(posedge sys_clk) disable iff (rst) !flashWeN |-> !flashCeN && flashOeN && !flashDqEnN;
  endproperty
  a_write_pins: assert property (p_write_pins) else $error("strobe low without select"); // R1

  property p_data_hold;
    @(posedge sys_clk) disable iff (rst) $rose(flashWeN) |-> !flashDqEnN && $stable(flashDqOut);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise"); // R2

  property p_reset_data;
    @(posedge sys_clk) disable iff (rst) s_accept(CMD_SW_RESET) ##0 !abortSeen && !bypassMode
      |-> ##2 !flashWeN && flashDqOut == `FH_D_RESET;
  endproperty
  a_reset_data: assert property (p_reset_data) else $error("reset code wrong"); // R6

  property p_abort_promote;
    @(posedge sys_clk) disable iff (rst) s_accept(CMD_SW_RESET) ##0 abortSeen
      |=> kind == CMD_BUF_ABORT_RESET ##1 flashDqOut == `FH_D_UNLOCK1;
  endproperty
  a_abort_promote: assert property (p_abort_promote) else $error("abort reset skipped"); // R11

  property p_bypass_promote;
    @(posedge sys_clk) disable iff (rst) s_accept(CMD_SW_RESET) ##0 !abortSeen && bypassMode
      |=> kind == CMD_BYPASS_RESET;
  endproperty
  a_bypass_promote: assert property (p_bypass_promote) else $error("bypass reset skipped"); // R12

  property p_lock_refuse;
    @(posedge sys_clk) disable iff (rst) s_accept(CMD_LOCK_PROGRAM) ##0
      !cmdData[`FH_LOCK_PWD_BIT] && !cmdData[`FH_LOCK_PERS_BIT] |=> error && flashWeN ##1 flashWeN;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("double lock not refused"); // R15

  property p_restart_width;
    @(posedge sys_clk) disable iff (rst) $rose(flashRestartN) |-> lowCount >= 8'(RP_MIN);
  endproperty
  a_restart_width: assert property (p_restart_width) else $error("restart pulse short"); // R5

  property p_busy_wait;
    @(posedge sys_clk) disable iff (rst) state == ST_POLL && !rbSync |=> state == ST_POLL && !done;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("left poll while busy"); // R4

  property p_exit_clears;
    @(posedge sys_clk) disable iff (rst) state == ST_HOLD && kind == CMD_EXIT && step == 2'h1
      |=> !cmdSetMode;
  endproperty
  a_exit_clears: assert property (p_exit_clears) else $error("exit left mode set"); // R22

  property p_guard_sector;
    @(posedge sys_clk) disable iff (rst) state == ST_STROBE && kind == CMD_GUARD_PROGRAM &&
      step == 2'h1 |-> flashAddr[`FH_SECTOR_LSB-1:0] == 16'h0000;
  endproperty
  a_guard_sector: assert property (p_guard_sector) else $error("guard address not sector"); // R3

endmodule : flash_host_ctrl

`default_nettype wire

/* sim/flash_dev_model.sv */
// flash_dev_model: behavioural parallel NOR device facing the host controller pins
// assumes pins come straight from flash_host_ctrl; no clock, all edge driven
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model #(
  parameter int  BUSY_NS = 200,
  parameter real MIN_NS  = 500.0
) (
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic        restartN,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic [15:0] faultBits,
  output logic      [15:0] dqIn,
  output logic             readyBusyN
);
  logic [15:0]   lockReg;
  logic [15:0]   lastOut;
  logic [15:0]   lastData;
  logic [25:0]   latAddr;
  logic [1023:0] guard;
  logic          lockMode;
  logic          guardMode;
  logic          bypass;
  logic          progArm;
  logic          exitArm;
  logic          pulseOk;
  int            writes;
  int            seqPos;
  realtime       lowAt;

  initial begin
    lockReg = 16'hffff;
    guard = '1;
    {lockMode, guardMode, bypass, progArm, exitArm, pulseOk} = 6'h00;
    lastOut = 16'h0000;
    lastData = 16'h0000;
    latAddr = 26'h0;
    readyBusyN = 1'b1;
    writes = 0;
    seqPos = 0;
    lowAt = 0.0;
  end

  function automatic logic [15:0] rdVal(input logic [25:0] a);
    if (guardMode) return {15'h0000, guard[a[25:16]]};
    if (lockMode && a[25:16] == 10'h000) return lockReg;
    if (faultBits != 16'h0000) return faultBits;
    return a[15:0] ^ 16'h5a5a ^ {6'h00, a[25:16]};
  endfunction : rdVal

  // released bus shows the inverse of the last value, never a stale copy
  always @(ceN or oeN or restartN or addr or guardMode or lockMode or faultBits or lastOut) begin
    dqIn = (!ceN && !oeN && restartN) ? rdVal(addr) : ~lastOut;
  end
  always @(posedge oeN or posedge ceN) lastOut <= dqIn;

  always @(negedge weN or negedge ceN) begin
    #1; // strobe and address move in one step; let address settle
    if (!weN && !ceN) latAddr <= addr;
  end

  task automatic take(input logic [25:0] a, input logic [15:0] d);
    if (progArm && d != 16'h00f0) begin
      progArm = 1'b0;
      if (guardMode) guard[a[25:16]] = 1'b0;
      else if (d[2:1] == 2'b00) lockReg = lockReg;
      else if (lockReg[2:1] != 2'b11) lockReg[0] = lockReg[0] & d[0];
      else lockReg[2:0] = lockReg[2:0] & d[2:0];
    end else if (exitArm) begin
      exitArm = 1'b0;
      if (d == 16'h0000) {lockMode, guardMode, bypass} = 3'b000;
    end else if (seqPos == 2) begin
      seqPos = 0;
      if (d == 16'h0020) bypass = 1'b1;
      if (d == 16'h0040) lockMode = 1'b1;
      if (d == 16'h00c0) guardMode = 1'b1;
    end else if (d == 16'h00f0 && !bypass) begin
      {seqPos, progArm} = '0;
      lockMode = 1'b0;
      guardMode = 1'b0;
    end else if (d == 16'h00aa && a[10:0] == 11'h555) seqPos = 1;
    else if (seqPos == 1 && d == 16'h0055) seqPos = 2;
    else if (d == 16'h00a0) progArm = 1'b1;
    else if (d == 16'h0090) exitArm = 1'b1;
    else if (d == 16'h0030 && guardMode) guard = '1;
    else seqPos = 0;
  endtask : take

  always @(posedge weN) begin
    if (!ceN && restartN) begin
      writes++;
      lastData = dq;
      take(latAddr, dq);
    end
  end

  // busy after each strobe rise; edges inside the busy time only extend nothing
  always @(posedge weN) begin
    if (!ceN && restartN) begin
      readyBusyN = 1'b0;
      #(BUSY_NS);
      readyBusyN = 1'b1;
    end
  end

  always @(negedge restartN) lowAt = $realtime;
  always @(posedge restartN) begin
    pulseOk = ($realtime - lowAt) >= MIN_NS;
    {lockMode, guardMode, bypass, progArm, exitArm} = 5'h00;
    seqPos = 0;
  end
endmodule : flash_dev_model
`default_nettype wire

/* sim/testbench.sv */
// testbench: drives flash_host_ctrl user port against the behavioural flash device
// assumes flash_host_pkg compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench
  import flash_host_pkg::*;
;
  logic sys_clk, rst, cmdValid, cmdReady, done, error, timeoutSeen, abortSeen, lastErr;
  logic flashCeN, flashWeN, flashOeN, flashRestartN, flashDqEnN, readyBusyN;
  cmd_kind_type cmdKind;
  logic [25:0] cmdAddr, flashAddr;
  logic [15:0] cmdData, rdData, flashDqOut, flashDqIn, faultBits;
  int          fail_count, comparisons, cycles, w;

  flash_host_ctrl uut (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .done(done), .error(error),
    .rdData(rdData), .timeoutSeen(timeoutSeen), .abortSeen(abortSeen), .flashCeN(flashCeN),
    .flashWeN(flashWeN), .flashOeN(flashOeN), .flashRestartN(flashRestartN),
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqEnN(flashDqEnN),
    .flashDqIn(flashDqIn), .readyBusyN(readyBusyN));

  flash_dev_model dev (.ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN),
    .restartN(flashRestartN), .addr(flashAddr), .dq(flashDqOut), .faultBits(faultBits),
    .dqIn(flashDqIn), .readyBusyN(readyBusyN));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // hold the request until the edge that takes it, then wait for done or error
  task automatic issue(input cmd_kind_type k, input logic [25:0] a, input logic [15:0] d);
    int n;
    cmdKind = k;
    cmdAddr = a;
    cmdData = d;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(posedge sys_clk) #2;
    @(posedge sys_clk) #2;
    cmdValid = 1'b0;
    n = 0;
    lastErr = error;
    while (n < 2000 && done !== 1'b1 && lastErr !== 1'b1) begin
      @(posedge sys_clk) #2;
      n++;
    end
    if (n == 2000) fail_count++;
  endtask : issue

  always @(posedge flashWeN) begin
    if (rst === 1'b0) chk1(~flashCeN & flashOeN & ~flashDqEnN, 1'b1);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    {fail_count, comparisons, cycles, w} = '0;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdKind = CMD_READ;
    cmdAddr = 26'h0;
    cmdData = 16'h0000;
    faultBits = 16'h0000;
    repeat (8) @(posedge sys_clk);
    #2 rst = 1'b0;
    issue(CMD_READ, 26'h0031234, 16'h0000);
    chk16(rdData, 16'h1234 ^ 16'h5a5a ^ 16'h0003);
    w = dev.writes;
    issue(CMD_SW_RESET, 26'h0123456, 16'h0000);
    chk16(16'(dev.writes - w), 16'h0001);
    chk16(dev.lastData, 16'h00f0);
    chk1(readyBusyN, 1'b1);
    issue(CMD_LOCK_PROGRAM, 26'h0, 16'hfff9);
    chk1(lastErr, 1'b1);
    issue(CMD_LOCK_ENTRY, 26'h0, 16'h0000);
    issue(CMD_LOCK_PROGRAM, 26'h0, 16'hfffd);
    issue(CMD_READ, 26'h0, 16'h0000);
    chk16(rdData, 16'hfffd);
    issue(CMD_LOCK_PROGRAM, 26'h0, 16'hfffb);
    issue(CMD_READ, 26'h0, 16'h0000);
    chk16(rdData, 16'hfffd);
    issue(CMD_READ, 26'h0010000, 16'h0000);
    chk16(rdData, 16'h5a5b);
    issue(CMD_EXIT, 26'h0, 16'h0000);
    issue(CMD_READ, 26'h0, 16'h0000);
    chk16(rdData, 16'h5a5a);
    issue(CMD_GUARD_ENTRY, 26'h0, 16'h0000);
    issue(CMD_GUARD_PROGRAM, 26'h0030000, 16'h0000);
    issue(CMD_READ, 26'h0030000, 16'h0000);
    chk16(rdData, 16'h0000);
    issue(CMD_READ, 26'h0040000, 16'h0000);
    chk16(rdData, 16'h0001);
    issue(CMD_GUARD_ERASE, 26'h0, 16'h0000);
    issue(CMD_READ, 26'h0030000, 16'h0000);
    chk16(rdData, 16'h0001);
    issue(CMD_EXIT, 26'h0, 16'h0000);
    issue(CMD_BYPASS_ENTRY, 26'h0, 16'h0000);
    w = dev.writes;
    issue(CMD_SW_RESET, 26'h0, 16'h0000);
    chk16(16'(dev.writes - w), 16'h0002);
    chk1(dev.bypass, 1'b0);
    faultBits = 16'h0020;
    issue(CMD_STATUS, 26'h0, 16'h0000);
    chk1(timeoutSeen, 1'b1);
    faultBits = 16'h0000;
    issue(CMD_SW_RESET, 26'h0, 16'h0000);
    chk1(timeoutSeen, 1'b0);
    faultBits = 16'h0002;
    issue(CMD_STATUS, 26'h0, 16'h0000);
    chk1(abortSeen, 1'b1);
    faultBits = 16'h0000;
    w = dev.writes;
    issue(CMD_SW_RESET, 26'h0, 16'h0000);
    chk16(16'(dev.writes - w), 16'h0003);
    chk1(abortSeen, 1'b0);
    issue(CMD_WRITE_RAW, 26'h0000555, 16'h00aa);
    issue(CMD_LOCK_ENTRY, 26'h0, 16'h0000);
    issue(CMD_RESTART, 26'h0, 16'h0000);
    chk1(dev.pulseOk, 1'b1);
    issue(CMD_READ, 26'h0, 16'h0000);
    chk16(rdData, 16'h5a5a);
    issue(CMD_LOCK_ENTRY, 26'h0, 16'h0000);
    issue(CMD_WRITE_RAW, 26'h0, 16'h00a0);
    issue(CMD_SW_RESET, 26'h0, 16'h0000);
    chk1(dev.lockMode, 1'b0);
    results();
  end
endmodule : testbench
`default_nettype wire
